/* src/hnar_defs.svh */
`ifndef HNAR_DEFS_SVH
`define HNAR_DEFS_SVH
`define HNAR_MAC_W        48
`define HNAR_NODE_W       8
`define HNAR_MULTICAST_STREAM_ID_W       8
`define HNAR_ETYPE_W      16
`define HNAR_LOCAL_DEPTH  8
`define HNAR_REMOTE_DEPTH 8
`define HNAR_GROUP_DEPTH  4
`define HNAR_IDX_W        3
`define HNAR_GIDX_W       2
`define HNAR_BCAST_MAC    48'hffff_ffff_ffff
`define HNAR_RSVD_MAC     48'h0119_a752_7696
`define HNAR_MGMT_ETYPE   16'h22e3
`define HNAR_ALL_NODES    8'hff
`define HNAR_GROUP_BIT    40
`endif

/* src/hnar_pkg.sv */
package hnar_pkg;
  typedef enum logic [2:0] {
    HNAR_DROP  = 3'h0,
    HNAR_MGMT  = 3'h1,
    HNAR_UCAST = 3'h3,
    HNAR_MCAST = 3'h2,
    HNAR_BCAST = 3'h6,
    HNAR_FLOOD = 3'h7
  } hnar_route_t;
  typedef enum logic [1:0] {
    HNAR_TBL_LOCAL  = 2'h0,
    HNAR_TBL_REMOTE = 2'h1,
    HNAR_TBL_GROUP  = 2'h2
  } hnar_tbl_t;
endpackage

/* src/hnar_cam.sv */
`timescale 1ns/1ns
`include "hnar_defs.svh"
// small associative table: flip-flop entries, write by index, match by key
module hnar_cam #(
  parameter int DEPTH = 8,
  parameter int IW    = 3
) (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic                    ce,
  input  wire logic                    wr_en,
  input  wire logic [IW-1:0]           wr_idx,
  input  wire logic                    wr_valid,
  input  wire logic [`HNAR_MAC_W-1:0]  wr_key,
  input  wire logic [`HNAR_NODE_W-1:0] wr_val,
  input  wire logic [`HNAR_MAC_W-1:0]  lk_key,
  output logic                         lk_hit,
  output logic [`HNAR_NODE_W-1:0]      lk_val
);
  logic [DEPTH-1:0]                   vld_q, vld_d;
  logic [`HNAR_MAC_W-1:0]             key_q [DEPTH];
  logic [`HNAR_MAC_W-1:0]             key_d [DEPTH];
  logic [`HNAR_NODE_W-1:0]            val_q [DEPTH];
  logic [`HNAR_NODE_W-1:0]            val_d [DEPTH];

  always_comb begin
    vld_d = vld_q;
    key_d = key_q;
    val_d = val_q;
    if (wr_en) begin
      vld_d[wr_idx] = wr_valid;
      key_d[wr_idx] = wr_key;
      val_d[wr_idx] = wr_val;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      vld_q <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        key_q[i] <= '0;
        val_q[i] <= '0;
      end
    end else if (ce) begin
      vld_q <= vld_d;
      key_q <= key_d;
      val_q <= val_d;
    end
  end

  always_comb begin
    lk_hit = 1'b0;
    lk_val = '0;
    for (int i = 0; i < DEPTH; i++) begin
      if (vld_q[i] && key_q[i] == lk_key && !lk_hit) begin
        lk_hit = 1'b1;
        lk_val = val_q[i];
      end
    end
  end
endmodule // hnar_cam

/* src/hnar_router.sv */
`timescale 1ns/1ns
`include "hnar_defs.svh"
module hnar_router
  import hnar_pkg::*;
(
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic                     ce,
  input  wire logic [`HNAR_MAC_W-1:0]   own_mac,
  input  wire logic                     bcast_copy_all,
  input  wire logic                     learn_valid,
  input  wire logic [`HNAR_IDX_W-1:0]   learn_idx,
  input  wire logic [`HNAR_MAC_W-1:0]   learn_mac,
  input  wire logic                     mgmt_local_wr,
  input  wire logic [`HNAR_IDX_W-1:0]   mgmt_local_idx,
  input  wire logic                     mgmt_local_vld,
  input  wire logic [`HNAR_MAC_W-1:0]   mgmt_local_mac,
  input  wire logic                     mgmt_remote_wr,
  input  wire logic [`HNAR_IDX_W-1:0]   mgmt_remote_idx,
  input  wire logic                     mgmt_remote_vld,
  input  wire logic [`HNAR_MAC_W-1:0]   mgmt_remote_mac,
  input  wire logic [`HNAR_NODE_W-1:0]  mgmt_remote_node,
  input  wire logic                     mgmt_group_wr,
  input  wire logic [`HNAR_GIDX_W-1:0]  mgmt_group_idx,
  input  wire logic                     mgmt_group_vld,
  input  wire logic [`HNAR_MAC_W-1:0]   mgmt_group_mac,
  input  wire logic [`HNAR_MULTICAST_STREAM_ID_W-1:0]  mgmt_group_multicast_stream_id,
  input  wire logic                     pkt_valid,
  input  wire logic [`HNAR_MAC_W-1:0]   pkt_dest_mac,
  input  wire logic [`HNAR_ETYPE_W-1:0] pkt_ethertype,
  output logic                          dec_valid,
  output hnar_route_t                   dec_route,
  output logic                          dec_to_medium,
  output logic                          dec_to_mgmt,
  output logic                          dec_broadcast_indicator_bit,
  output logic [`HNAR_NODE_W-1:0]       dec_target_node_field,
  output logic [`HNAR_MULTICAST_STREAM_ID_W-1:0]       dec_multicast_stream_id
);
  ////////////////////////////////////////////////////////////////////////////
  // tables
  logic                         loc_wr, loc_wv;
  logic [`HNAR_IDX_W-1:0]       loc_idx;
  logic [`HNAR_MAC_W-1:0]       loc_mac;
  logic                         loc_hit, rem_hit, grp_hit;
  logic [`HNAR_NODE_W-1:0]      rem_node, grp_multicast_stream_id;

  // management write has priority over learning in the same cycle
  always_comb begin
    loc_wr  = mgmt_local_wr | learn_valid;
    loc_idx = mgmt_local_wr ? mgmt_local_idx : learn_idx;
    loc_wv  = mgmt_local_wr ? mgmt_local_vld : 1'b1;
    loc_mac = mgmt_local_wr ? mgmt_local_mac : learn_mac;
  end

  hnar_cam #(.DEPTH(`HNAR_LOCAL_DEPTH), .IW(`HNAR_IDX_W)) u_local_address_table (
    .clk      (clk),
    .rst      (rst),
    .ce       (ce),
    .wr_en    (loc_wr),
    .wr_idx   (loc_idx),
    .wr_valid (loc_wv),
    .wr_key   (loc_mac),
    .wr_val   ('0),
    .lk_key   (pkt_dest_mac),
    .lk_hit   (loc_hit),
    .lk_val   ()
  );

  hnar_cam #(.DEPTH(`HNAR_REMOTE_DEPTH), .IW(`HNAR_IDX_W)) u_remote_address_table (
    .clk      (clk),
    .rst      (rst),
    .ce       (ce),
    .wr_en    (mgmt_remote_wr),
    .wr_idx   (mgmt_remote_idx),
    .wr_valid (mgmt_remote_vld),
    .wr_key   (mgmt_remote_mac),
    .wr_val   (mgmt_remote_node),
    .lk_key   (pkt_dest_mac),
    .lk_hit   (rem_hit),
    .lk_val   (rem_node)
  );

  hnar_cam #(.DEPTH(`HNAR_GROUP_DEPTH), .IW(`HNAR_GIDX_W)) u_group_table (
    .clk      (clk),
    .rst      (rst),
    .ce       (ce),
    .wr_en    (mgmt_group_wr),
    .wr_idx   (mgmt_group_idx),
    .wr_valid (mgmt_group_vld),
    .wr_key   (mgmt_group_mac),
    .wr_val   (mgmt_group_multicast_stream_id),
    .lk_key   (pkt_dest_mac),
    .lk_hit   (grp_hit),
    .lk_val   (grp_multicast_stream_id)
  );

  ////////////////////////////////////////////////////////////////////////////
  // classification
  function automatic logic is_group(input logic [`HNAR_MAC_W-1:0] mac);
    return mac[`HNAR_GROUP_BIT];
  endfunction

  logic                      valid_q, valid_d, med_q, med_d, mgmt_q, mgmt_d, brc_q, brc_d;
  hnar_route_t               route_q, route_d;
  logic [`HNAR_NODE_W-1:0]   node_q, node_d;
  logic [`HNAR_MULTICAST_STREAM_ID_W-1:0]   multicast_stream_id_q, multicast_stream_id_d;
  logic                      own_hit, rsvd_hit, bc_hit;

  always_comb begin
    own_hit  = pkt_dest_mac == own_mac;
    rsvd_hit = pkt_dest_mac == `HNAR_RSVD_MAC;
    bc_hit   = pkt_dest_mac == `HNAR_BCAST_MAC;
    valid_d  = pkt_valid;
    route_d  = HNAR_FLOOD;
    med_d    = 1'b0;
    mgmt_d   = 1'b0;
    brc_d    = 1'b0;
    node_d   = '0;
    multicast_stream_id_d   = '0;
    if (own_hit || rsvd_hit) begin
      route_d = HNAR_MGMT;
      mgmt_d  = 1'b1;
    end else if (loc_hit) begin
      route_d = HNAR_DROP;
    end else if (rem_hit) begin
      route_d = HNAR_UCAST;
      med_d   = 1'b1;
      node_d  = rem_node;
    end else if (is_group(pkt_dest_mac) && !bc_hit && grp_hit) begin
      route_d = HNAR_MCAST;
      med_d   = 1'b1;
      multicast_stream_id_d  = grp_multicast_stream_id;
    end else if (bc_hit) begin
      route_d = HNAR_BCAST;
      med_d   = 1'b1;
      brc_d   = 1'b1;
      node_d  = `HNAR_ALL_NODES;
      mgmt_d  = (pkt_ethertype == `HNAR_MGMT_ETYPE) || bcast_copy_all;
    end else begin
      route_d = HNAR_FLOOD;
      med_d   = 1'b1;
      brc_d   = 1'b1;
      node_d  = `HNAR_ALL_NODES;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      valid_q <= 1'b0;
      route_q <= HNAR_DROP;
      med_q   <= 1'b0;
      mgmt_q  <= 1'b0;
      brc_q   <= 1'b0;
      node_q  <= '0;
      multicast_stream_id_q  <= '0;
    end else if (ce) begin
      valid_q <= valid_d;
      route_q <= route_d;
      med_q   <= med_d;
      mgmt_q  <= mgmt_d;
      brc_q   <= brc_d;
      node_q  <= node_d;
      multicast_stream_id_q  <= multicast_stream_id_d;
    end
  end

  assign dec_valid                   = valid_q;
  assign dec_route                   = route_q;
  assign dec_to_medium               = med_q;
  assign dec_to_mgmt                 = mgmt_q;
  assign dec_broadcast_indicator_bit = brc_q;
  assign dec_target_node_field       = node_q;
  assign dec_multicast_stream_id     = multicast_stream_id_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_bc_pkt;
    ce && pkt_valid && pkt_dest_mac == `HNAR_BCAST_MAC && pkt_dest_mac != own_mac && !loc_hit && !rem_hit;
  endsequence

  chk_bcast_sets_bit: assert property (@(posedge clk) disable iff (rst)
    s_bc_pkt |=> dec_valid && dec_broadcast_indicator_bit && dec_route == HNAR_BCAST)
    else $error("broadcast packet without indicator bit");
  chk_bcast_mgmt_copy: assert property (@(posedge clk) disable iff (rst)
    s_bc_pkt ##0 (pkt_ethertype == `HNAR_MGMT_ETYPE) |=> dec_to_mgmt && dec_to_medium)
    else $error("management ethertype broadcast not copied");
  chk_bcast_target_ff: assert property (@(posedge clk) disable iff (rst)
    dec_valid && dec_broadcast_indicator_bit |-> dec_target_node_field == `HNAR_ALL_NODES)
    else $error("broadcast target not all nodes");
  chk_own_to_mgmt: assert property (@(posedge clk) disable iff (rst)
    ce && pkt_valid && pkt_dest_mac == own_mac |=> dec_to_mgmt && !dec_to_medium)
    else $error("own address not sent to management");
  chk_rsvd_to_mgmt: assert property (@(posedge clk) disable iff (rst)
    ce && pkt_valid && pkt_dest_mac == `HNAR_RSVD_MAC |=> dec_route == HNAR_MGMT && dec_to_mgmt)
    else $error("reserved address not sent to management");
  chk_local_drop: assert property (@(posedge clk) disable iff (rst)
    ce && pkt_valid && loc_hit && pkt_dest_mac != own_mac && pkt_dest_mac != `HNAR_RSVD_MAC
    |=> dec_route == HNAR_DROP && !dec_to_medium && !dec_to_mgmt)
    else $error("local hit not dropped");
  chk_remote_node: assert property (@(posedge clk) disable iff (rst)
    ce && pkt_valid && rem_hit && !loc_hit && !own_hit && !rsvd_hit
    |=> dec_route == HNAR_UCAST && dec_target_node_field == $past(rem_node) && !dec_broadcast_indicator_bit)
    else $error("remote hit not unicast to resolved node");
  chk_flood_all_nodes: assert property (@(posedge clk) disable iff (rst)
    dec_valid && dec_route == HNAR_FLOOD |-> dec_broadcast_indicator_bit && dec_to_medium
    && dec_target_node_field == `HNAR_ALL_NODES)
    else $error("flood without indicator bit or all-nodes target");
  chk_one_decision: assert property (@(posedge clk) disable iff (rst)
    dec_valid && dec_to_medium |-> dec_route != HNAR_DROP && dec_route != HNAR_MGMT)
    else $error("conflicting decision");
endmodule // hnar_router

/* tb/hnar_fmap_model.sv */
`timescale 1ns/1ns
// flow mapper stand-in: counts every decision handed over
module hnar_fmap_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        dec_valid,
  output logic [15:0]      dec_cnt_q
);
  logic [15:0] dec_cnt_d;
  always_comb dec_cnt_d = dec_valid ? dec_cnt_q + 16'h1 : dec_cnt_q;
  always_ff @(posedge clk) dec_cnt_q <= rst ? 16'h0 : dec_cnt_d;
endmodule // hnar_fmap_model

/* tb/testbench.sv */
`timescale 1ns/1ns
`include "hnar_defs.svh"
module testbench;
  import hnar_pkg::*;
  localparam logic [47:0] A = 48'h0200_0000_00a0, B = 48'h0200_0000_00b0, C = 48'h0200_0000_00c0;
  localparam logic [47:0] D = 48'h0200_0000_00d0, U = 48'h0200_0000_00ee, G = 48'h0100_5e00_0001;
  localparam logic [47:0] H = 48'h0300_0000_0001, F = `HNAR_BCAST_MAC;
  logic        clk = 1'b0, rst = 1'b1, ce = 1'b1, bca = 1'b0, lv = 1'b0, mlw = 1'b0, mlv = 1'b0;
  logic        mrw = 1'b0, mrv = 1'b0, mgw = 1'b0, mgv = 1'b0, pv = 1'b0, dv, tm, tg, bib;
  logic [2:0]  li = 3'h0, mli = 3'h0, mri = 3'h0;
  logic [1:0]  mgi = 2'h0;
  logic [47:0] own = 48'h0200_0000_0001, lm = 48'h0, mlm = 48'h0, mrm = 48'h0, mgm = 48'h0, pd = 48'h0;
  logic [7:0]  mrn = 8'h0, mgs = 8'h0, tgt, ms;
  logic [15:0] pe = 16'h0, n_dec;
  hnar_route_t rt;
  logic [19:0] expq[$];
  logic [19:0] e;
  int          miscompares = 0, num_checks = 0, sent = 0;

  always #4 clk = ~clk;

  hnar_router u_hnar_router (.clk(clk), .rst(rst), .ce(ce), .own_mac(own), .bcast_copy_all(bca),
    .learn_valid(lv), .learn_idx(li), .learn_mac(lm), .mgmt_local_wr(mlw), .mgmt_local_idx(mli),
    .mgmt_local_vld(mlv), .mgmt_local_mac(mlm), .mgmt_remote_wr(mrw), .mgmt_remote_idx(mri),
    .mgmt_remote_vld(mrv), .mgmt_remote_mac(mrm), .mgmt_remote_node(mrn), .mgmt_group_wr(mgw),
    .mgmt_group_idx(mgi), .mgmt_group_vld(mgv), .mgmt_group_mac(mgm), .mgmt_group_multicast_stream_id(mgs),
    .pkt_valid(pv), .pkt_dest_mac(pd), .pkt_ethertype(pe), .dec_valid(dv), .dec_route(rt),
    .dec_to_medium(tm), .dec_to_mgmt(tg), .dec_broadcast_indicator_bit(bib),
    .dec_target_node_field(tgt), .dec_multicast_stream_id(ms));
  hnar_fmap_model u_hnar_fmap_model (.clk(clk), .rst(rst), .dec_valid(dv), .dec_cnt_q(n_dec));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic pkt(input logic [47:0] d, input hnar_route_t r, input logic [7:0] t, input logic [7:0] m,
                     input logic g, input logic [15:0] et = 16'h0800);
    pv = 1'b1;
    pd = d;
    pe = et;
    sent++;
    expq.push_back({r, t, m, g});
    @(posedge clk);
    #1;
  endtask

  task automatic idle;
    pv = 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask

  // decision checker, expected fields come from the queued packet
  always @(posedge clk) begin
    #2;
    if (dv === 1'b1 && expq.size() == 0) chk(48'h1, 48'h0);
    else if (dv === 1'b1) begin
      e = expq.pop_front();
      chk(rt, e[19:17]);
      chk(bib, e[19:18] == 2'h3);
      chk(tm, e[19:18] != 2'h0);
      chk(tg, e[0]);
      if (e[19:18] == 2'h3) chk(tgt, 8'hff);
      if (e[19:17] == HNAR_UCAST) chk(tgt, e[16:9]);
      if (e[19:17] == HNAR_MCAST) chk(ms, e[8:1]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    repeat (3) @(posedge clk);
    #1;
    chk(dv, 1'b0);
    chk(rt, HNAR_DROP);
    rst = 1'b0;
    $display("test reset done");
  endtask

  // learning alone first, then learning and management together: management wins, u is lost
  task automatic t_fill;
    {lv, lm, mlw, mlv, mli, mlm} = {1'b1, A, 1'b0, 1'b1, 3'h1, B};
    {mrw, mrv, mrm, mrn, mgw, mgv, mgm, mgs} = {2'h3, C, 8'h05, 2'h3, G, 8'h09};
    @(posedge clk);
    #1;
    {li, lm, mlw, mgw, mri, mrm, mrn} = {3'h3, U, 1'b1, 1'b0, 3'h1, A, 8'h07};
    @(posedge clk);
    #1;
    {lv, mrw, mli, mlm} = {2'h0, 3'h2, own};
    @(posedge clk);
    #1;
    mlw = 1'b0;
    $display("test fill done");
  endtask

  task automatic t_routes;
    pkt(own, HNAR_MGMT, 8'h0, 8'h0, 1'b1);
    pkt(`HNAR_RSVD_MAC, HNAR_MGMT, 8'h0, 8'h0, 1'b1);
    pkt(A, HNAR_DROP, 8'h0, 8'h0, 1'b0);
    pkt(B, HNAR_DROP, 8'h0, 8'h0, 1'b0);
    pkt(C, HNAR_UCAST, 8'h05, 8'h0, 1'b0);
    pkt(G, HNAR_MCAST, 8'h0, 8'h09, 1'b0);
    pkt(F, HNAR_BCAST, 8'hff, 8'h0, 1'b1, `HNAR_MGMT_ETYPE);
    pkt(U, HNAR_FLOOD, 8'hff, 8'h0, 1'b0);
    pkt(H, HNAR_FLOOD, 8'hff, 8'h0, 1'b0);
    idle();
    $display("test routes done");
  endtask

  task automatic t_copy;
    for (int b = 0; b < 2; b++) begin
      bca = 1'(b);
      pkt(F, HNAR_BCAST, 8'hff, 8'h0, 1'(b));
      idle();
    end
    $display("test copy done");
  endtask

  // a remote write becomes visible one cycle later, both to add and remove
  task automatic t_write_vis;
    {mrw, mrv, mri, mrm, mrn} = {2'h3, 3'h2, D, 8'h33};
    pkt(D, HNAR_FLOOD, 8'hff, 8'h0, 1'b0);
    mrv = 1'b0;
    pkt(D, HNAR_UCAST, 8'h33, 8'h0, 1'b0);
    mrw = 1'b0;
    pkt(D, HNAR_FLOOD, 8'hff, 8'h0, 1'b0);
    idle();
    chk(n_dec, sent);
    chk(48'(expq.size()), 48'h0);
    $display("test write visibility done");
  endtask

  // clock enable low: no packet taken, no table write lands
  task automatic t_freeze;
    ce = 1'b0;
    {pv, pd, mrw, mrv, mri, mrm, mrn} = {1'b1, U, 2'h3, 3'h3, U, 8'h44};
    repeat (2) @(posedge clk);
    #1;
    chk(dv, 1'b0);
    {pv, mrw, ce} = 3'h1;
    pkt(U, HNAR_FLOOD, 8'hff, 8'h0, 1'b0);
    idle();
    chk(48'(expq.size()), 48'h0);
    $display("test freeze done");
  endtask

  initial begin
    t_reset();
    t_fill();
    t_routes();
    t_copy();
    t_write_vis();
    t_freeze();
    conclude();
  end

  // the whole run needs well under 100 cycles
  initial begin
    #(400 * 8);
    miscompares++;
    conclude();
  end
endmodule // testbench
